// >>> design/acs_pkg.sv
// constants, register map and carrier types of the conversion sequencer
package acs_pkg;

  // timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int RC_DELAY_NS     = 160;
  localparam int RC_DELAY_CYC    = (RC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TADS       = 11;
  localparam int ABORT_TADS      = 2;
  localparam int RESULT_BITS     = 10;

  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_ANALOG  = 5'h04;
  localparam logic [4:0] OFS_RES_HI  = 5'h08;
  localparam logic [4:0] OFS_RES_LO  = 5'h0C;
  localparam logic [4:0] OFS_FLAGS   = 5'h10;
  localparam logic [4:0] OFS_MASK    = 5'h14;

  // control register fields
  localparam int CTL_POWER_BIT   = 0;
  localparam int CTL_RUN_BIT     = 1;
  localparam int CTL_CHAN_LSB    = 2;
  localparam int CTL_REF_BIT     = 6;
  localparam int CTL_FORMAT_BIT  = 7;

  // analog select register fields
  localparam int ANA_PINS_LSB    = 0;
  localparam int ANA_CLKSEL_LSB  = 4;

  // flag and mask register field
  localparam int FLAG_DONE_BIT   = 6;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ANALOG_RST  = 8'h0F;
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;

  // conversion clock select codes
  localparam logic [2:0] CLKSEL_DIV2  = 3'h0;
  localparam logic [2:0] CLKSEL_DIV8  = 3'h1;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV4  = 3'h4;
  localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
  localparam logic [1:0] CLKSEL_RC_LO = 2'h3;

  typedef enum {
    ST_IDLE,
    ST_RC_WAIT,
    ST_CONV,
    ST_ABORT
  } acs_state_type;

  // drive toward the analog multiplexer and converter core
  typedef struct packed {
    logic [1:0]             channel_select;
    logic                   reference_select;
    logic                   hold;
    logic [RESULT_BITS-1:0] trial_code;
    logic [3:0]             digital_input_disable;
    logic                   core_enable;
  } acs_analog_type;

endpackage

// >>> design/acs_bit_clock.sv
// conversion bit clock generator: oscillator divider or synchronised rc clock
`timescale 1ns/100ps
module acs_bit_clock (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       enable,
  input  wire logic [2:0] conversion_clock_select,
  // dedicated rc clock pin
  input  wire logic       rc_clk_pin,
  // one pulse per conversion bit period
  output logic            tad_tick
);

  logic [5:0] div_ff;
  logic [5:0] nxt_div;
  logic       rc_meta_ff;
  logic       rc_sync_ff;
  logic       rc_last_ff;
  logic       tick_ff;
  logic       nxt_tick;

  function automatic logic [5:0] divide_last(input logic [2:0] sel);
    case (sel)
      acs_pkg::CLKSEL_DIV2:  divide_last = 6'h01;
      acs_pkg::CLKSEL_DIV4:  divide_last = 6'h03;
      acs_pkg::CLKSEL_DIV8:  divide_last = 6'h07;
      acs_pkg::CLKSEL_DIV16: divide_last = 6'h0F;
      acs_pkg::CLKSEL_DIV32: divide_last = 6'h1F;
      default:               divide_last = 6'h3F;
    endcase
  endfunction

  always_comb begin
    nxt_div  = 6'h00;
    nxt_tick = 1'b0;
    if (enable) begin
      if (conversion_clock_select[1:0] == acs_pkg::CLKSEL_RC_LO) begin
        nxt_tick = rc_sync_ff & ~rc_last_ff; // [RULE5]
      end else if (div_ff == divide_last(conversion_clock_select)) begin
        nxt_tick = 1'b1; // [RULE5]
      end else begin
        nxt_div = div_ff + 6'h01;
      end
    end
  end

  // the rc pin is foreign to clk, so it passes two flops before edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff     <= 6'h00;
      tick_ff    <= 1'b0;
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_last_ff <= 1'b0;
    end else begin
      div_ff     <= nxt_div;
      tick_ff    <= nxt_tick;
      rc_meta_ff <= rc_clk_pin;
      rc_sync_ff <= rc_meta_ff;
      rc_last_ff <= rc_sync_ff;
    end
  end

  assign tad_tick = tick_ff;

endmodule

// >>> design/acs_sequencer.sv
// four channel 10-bit successive approximation conversion sequencer
//
// Contract
// [RULE1] one of four channels reaches the sample and hold, chosen by channel_select
// [RULE2] result is built by successive approximation, kept as 10-bit binary
// [RULE3] reference_select one picks external reference pin, zero the supply
// [RULE4] a conversion lasts eleven bit clock periods from start to completion
// [RULE5] conversion_clock_select picks oscillator divide 2..64 or the rc clock
// [RULE6] software keeps the bit period at least 1.6 microseconds
// [RULE7] writing one to run/done starts a conversion of the sampled channel
// [RULE8] completion clears run/done, sets done flag bit 6, may raise interrupt
// [RULE9] clearing run/done mid conversion aborts, previous result is kept
// [RULE10] after abort wait two bit periods, then acquisition restarts; hold drops at the abort already, only the next start waits
// [RULE11] software powers on and starts in separate writes
// [RULE12] result_format_select bit 7 chooses left or right justification
// [RULE13] analog_pin_select disables digital input buffers; software sets direction
// [RULE14] left: high byte eight msbs; right: high byte two msbs, low eight
// [RULE15] reset turns converter off and aborts, result pair unchanged
// [RULE16] with rc clock the start waits one instruction cycle
// [RULE17] sleep with non-rc clock aborts and turns core off, power bit kept
// [RULE18] both result bytes change together with run/done clearing
`timescale 1ns/100ps
module acs_sequencer (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // avalon-mm slave
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // interrupt
  output logic                       irq,
  // system
  input  wire logic                  sleep_req,
  input  wire logic                  rc_clk_pin,
  // analog core
  input  wire logic                  comparator_high,
  output acs_pkg::acs_analog_type    analog_out
);

  localparam int RB = acs_pkg::RESULT_BITS;

  acs_pkg::acs_state_type  state_ff;
  acs_pkg::acs_state_type  nxt_state;
  logic [7:0]              control_ff;
  logic [7:0]              nxt_control;
  logic [7:0]              analog_ff;
  logic [7:0]              nxt_analog;
  logic [7:0]              flags_ff;
  logic [7:0]              nxt_flags;
  logic [7:0]              mask_ff;
  logic [7:0]              nxt_mask;
  logic                    sleep_off_ff;
  logic                    nxt_sleep_off;
  logic [3:0]              tad_cnt_ff;
  logic [3:0]              nxt_tad_cnt;
  logic [2:0]              wait_cnt_ff;
  logic [2:0]              nxt_wait_cnt;
  logic [RB-1:0]           sar_ff;
  logic [RB-1:0]           nxt_sar;
  logic [3:0]              bit_ff;
  logic [3:0]              nxt_bit;
  logic [RB-1:0]           result_ff;
  logic [RB-1:0]           nxt_result;
  logic                    result_load;
  logic                    wait_ff;
  logic                    nxt_wait;
  logic [31:0]             rdata_ff;
  logic [31:0]             nxt_rdata;
  logic                    irq_ff;
  logic                    nxt_irq;
  acs_pkg::acs_analog_type ana_ff;
  acs_pkg::acs_analog_type nxt_ana;
  logic                    cmp_meta_ff;
  logic                    cmp_sync_ff;
  logic                    tad_tick;
  logic                    active;
  logic                    rc_mode;
  logic                    acc_wr;
  logic                    acc_rd;
  logic                    done_evt;
  logic [RB-1:0]           decided;

  // placement of the raw result across the byte pair
  function automatic logic [7:0] result_byte(input logic [RB-1:0] r, input logic right,
                                             input logic high);
    if (right) begin
      result_byte = high ? {6'h00, r[9:8]} : r[7:0]; // [RULE14]
    end else begin
      result_byte = high ? r[9:2] : {r[1:0], 6'h00}; // [RULE14]
    end
  endfunction

  assign active  = control_ff[acs_pkg::CTL_POWER_BIT] & ~sleep_off_ff;
  assign rc_mode = analog_ff[acs_pkg::ANA_CLKSEL_LSB +: 2] == acs_pkg::CLKSEL_RC_LO;
  // a request is taken on the edge where waitrequest is already low
  assign acc_wr  = avs_write & ~wait_ff;
  assign acc_rd  = avs_read & ~wait_ff;

  acs_bit_clock u_bit_clock (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .enable                  (active),
    .conversion_clock_select (analog_ff[acs_pkg::ANA_CLKSEL_LSB +: 3]),
    .rc_clk_pin              (rc_clk_pin),
    .tad_tick                (tad_tick)
  );

  // register bus and interrupt
  always_comb begin
    nxt_wait  = ~((avs_read | avs_write) & wait_ff);
    nxt_rdata = 32'h0000_0000;
    if (avs_read & wait_ff) begin
      case (avs_address)
        acs_pkg::OFS_CONTROL: nxt_rdata = {24'h00_0000, control_ff};
        acs_pkg::OFS_ANALOG:  nxt_rdata = {24'h00_0000, analog_ff};
        acs_pkg::OFS_RES_HI: // [RULE12]
          nxt_rdata = {24'h00_0000,
                       result_byte(result_ff, control_ff[acs_pkg::CTL_FORMAT_BIT], 1'b1)};
        acs_pkg::OFS_RES_LO: // [RULE12]
          nxt_rdata = {24'h00_0000,
                       result_byte(result_ff, control_ff[acs_pkg::CTL_FORMAT_BIT], 1'b0)};
        acs_pkg::OFS_FLAGS:   nxt_rdata = {24'h00_0000, flags_ff};
        acs_pkg::OFS_MASK:    nxt_rdata = {24'h00_0000, mask_ff};
        default:              nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_analog = analog_ff;
    nxt_mask   = mask_ff;
    nxt_flags  = flags_ff;
    if (acc_wr && avs_address == acs_pkg::OFS_ANALOG) begin
      nxt_analog = {1'b0, avs_writedata[6:0]};
    end
    if (acc_wr && avs_address == acs_pkg::OFS_MASK) begin
      nxt_mask = avs_writedata[7:0] & 8'h40;
    end
    // only bits actually returned are cleared, so a new event is never lost
    if (acc_rd && avs_address == acs_pkg::OFS_FLAGS) begin
      nxt_flags = flags_ff & ~rdata_ff[7:0];
    end
    if (done_evt) begin
      nxt_flags[acs_pkg::FLAG_DONE_BIT] = 1'b1; // [RULE8]
    end
    nxt_irq = |(nxt_flags & nxt_mask); // [RULE8]
  end

  // conversion sequencing
  always_comb begin
    nxt_state     = state_ff;
    nxt_control   = control_ff;
    nxt_tad_cnt   = tad_cnt_ff;
    nxt_wait_cnt  = wait_cnt_ff;
    nxt_sar       = sar_ff;
    nxt_bit       = bit_ff;
    nxt_result    = result_ff;
    result_load   = 1'b0;
    done_evt      = 1'b0;
    decided       = sar_ff;
    if (!cmp_sync_ff) begin
      decided[bit_ff] = 1'b0; // [RULE2]
    end
    if (acc_wr && avs_address == acs_pkg::OFS_CONTROL) begin
      nxt_control = avs_writedata[7:0] & 8'hCF; // [RULE7]
    end
    // sleep on an oscillator-derived clock stops the core, power bit stays
    nxt_sleep_off = sleep_req & ~rc_mode & nxt_control[acs_pkg::CTL_POWER_BIT]; // [RULE17]
    case (state_ff)
      acs_pkg::ST_IDLE: begin
        nxt_tad_cnt  = 4'h0;
        nxt_wait_cnt = 3'h0;
        if (control_ff[acs_pkg::CTL_RUN_BIT] && active) begin
          nxt_state = rc_mode ? acs_pkg::ST_RC_WAIT : acs_pkg::ST_CONV; // [RULE7] [RULE16]
        end
      end
      acs_pkg::ST_RC_WAIT: begin
        nxt_wait_cnt = wait_cnt_ff + 3'h1;
        if (!nxt_control[acs_pkg::CTL_RUN_BIT]) begin
          nxt_state    = acs_pkg::ST_ABORT; // [RULE9]
          nxt_wait_cnt = 3'h0;
        end else if (32'(wait_cnt_ff) == acs_pkg::RC_DELAY_CYC - 1) begin
          nxt_state    = acs_pkg::ST_CONV; // [RULE16]
          nxt_wait_cnt = 3'h0;
        end
      end
      acs_pkg::ST_CONV: begin
        if (!nxt_control[acs_pkg::CTL_RUN_BIT] || nxt_sleep_off) begin
          nxt_state    = acs_pkg::ST_ABORT; // [RULE9] [RULE17]
          nxt_wait_cnt = 3'h0;
          nxt_control[acs_pkg::CTL_RUN_BIT] = 1'b0;
        end else if (tad_tick) begin
          nxt_tad_cnt = tad_cnt_ff + 4'h1; // [RULE4]
          if (tad_cnt_ff == 4'h0) begin
            nxt_sar      = '0;
            nxt_sar[RB-1] = 1'b1; // [RULE2]
            nxt_bit      = 4'(RB - 1);
          end else if (32'(tad_cnt_ff) == acs_pkg::CONV_TADS - 1) begin
            nxt_result  = decided; // [RULE18]
            result_load = 1'b1; // [RULE9]
            done_evt    = 1'b1; // [RULE8]
            nxt_state   = acs_pkg::ST_IDLE;
            // a fresh software start in the same cycle outranks the hardware clear
            if (!(acc_wr && avs_address == acs_pkg::OFS_CONTROL &&
                  avs_writedata[acs_pkg::CTL_RUN_BIT])) begin
              nxt_control[acs_pkg::CTL_RUN_BIT] = 1'b0; // [RULE8] [RULE18]
            end
          end else begin
            nxt_sar = decided; // [RULE2]
            if (bit_ff != 4'h0) begin
              nxt_sar[bit_ff - 4'h1] = 1'b1;
              nxt_bit = bit_ff - 4'h1;
            end
          end
        end
      end
      acs_pkg::ST_ABORT: begin
        if (tad_tick) begin
          nxt_wait_cnt = wait_cnt_ff + 3'h1;
          if (32'(wait_cnt_ff) == acs_pkg::ABORT_TADS - 1) begin
            nxt_state = acs_pkg::ST_IDLE; // [RULE10]
          end
        end
      end
      default: begin
        nxt_state = acs_pkg::ST_IDLE;
      end
    endcase
  end

  // analog drive
  always_comb begin
    nxt_ana.channel_select        = nxt_control[acs_pkg::CTL_CHAN_LSB +: 2]; // [RULE1]
    nxt_ana.reference_select      = nxt_control[acs_pkg::CTL_REF_BIT]; // [RULE3]
    // sample switch opens only while bits are being decided; otherwise it acquires
    nxt_ana.hold                  = nxt_state == acs_pkg::ST_CONV; // [RULE10]
    nxt_ana.trial_code            = nxt_sar;
    nxt_ana.digital_input_disable = nxt_analog[acs_pkg::ANA_PINS_LSB +: 4]; // [RULE13]
    nxt_ana.core_enable           = nxt_control[acs_pkg::CTL_POWER_BIT] & ~nxt_sleep_off;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff     <= acs_pkg::ST_IDLE; // [RULE15]
      control_ff   <= acs_pkg::CONTROL_RST; // [RULE15]
      analog_ff    <= acs_pkg::ANALOG_RST;
      flags_ff     <= acs_pkg::FLAGS_RST;
      mask_ff      <= acs_pkg::MASK_RST;
      sleep_off_ff <= 1'b0;
      tad_cnt_ff   <= 4'h0;
      wait_cnt_ff  <= 3'h0;
      sar_ff       <= '0;
      bit_ff       <= 4'h0;
      wait_ff      <= 1'b1;
      rdata_ff     <= 32'h0000_0000;
      irq_ff       <= 1'b0;
      ana_ff       <= '0;
      cmp_meta_ff  <= 1'b0;
      cmp_sync_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      control_ff   <= nxt_control;
      analog_ff    <= nxt_analog;
      flags_ff     <= nxt_flags;
      mask_ff      <= nxt_mask;
      sleep_off_ff <= nxt_sleep_off;
      tad_cnt_ff   <= nxt_tad_cnt;
      wait_cnt_ff  <= nxt_wait_cnt;
      sar_ff       <= nxt_sar;
      bit_ff       <= nxt_bit;
      wait_ff      <= nxt_wait;
      rdata_ff     <= nxt_rdata;
      irq_ff       <= nxt_irq;
      ana_ff       <= nxt_ana;
      cmp_meta_ff  <= comparator_high;
      cmp_sync_ff  <= cmp_meta_ff;
    end
  end

  // result pair has no reset: its contents survive a device reset
  // a completion that meets the reset edge must not load either
  always_ff @(posedge clk) begin
    if (rst_n && result_load) begin
      result_ff <= nxt_result; // [RULE15] [RULE18]
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq             = irq_ff;
  assign analog_out      = ana_ff;

endmodule

// >>> tb/acs_sequencer_props.sv
// port level checks of the conversion sequencer
`timescale 1ns/100ps
module acs_sequencer_props (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // register bus
  input wire logic [4:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // interrupt, system and core
  input wire logic                    irq,
  input wire logic                    sleep_req,
  input wire acs_pkg::acs_analog_type analog_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a write that finishes at this edge
  sequence wr_done(logic [4:0] a);
    avs_write && !avs_waitrequest && avs_address == a;
  endsequence
  sequence core_off;
    !analog_out.core_enable && !analog_out.hold;
  endsequence
  chk_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero outside an answer");
  chk_chan_follow: assert property (
    wr_done(5'h00) |-> ##2 analog_out.channel_select == $past(avs_writedata[3:2], 2))
    else $error("channel select does not follow control");
  chk_ref_follow: assert property (
    wr_done(5'h00) |-> ##2 analog_out.reference_select == $past(avs_writedata[6], 2))
    else $error("reference select does not follow control");
  chk_pin_follow: assert property (
    wr_done(5'h04) |-> ##2 analog_out.digital_input_disable == $past(avs_writedata[3:0], 2))
    else $error("input buffer disable does not follow pin select");
  chk_trial_first: assert property (
    $rose(analog_out.hold) |-> ##[0:140] analog_out.trial_code == 10'h200)
    else $error("first trial word is not the midpoint");
  chk_reset_off: assert property ($rose(rst_n) |-> core_off ##0 !irq)
    else $error("core active or irq high after reset");
  chk_sleep_off: assert property (
    $rose(sleep_req) && analog_out.hold |-> ##[1:4] !analog_out.core_enable)
    else $error("sleep did not turn the core off");
  chk_irq_masked: assert property (
    avs_write && !avs_waitrequest && avs_address == 5'h14 && !avs_writedata[6] |-> ##2 !irq)
    else $error("irq high with done masked");
endmodule

bind acs_sequencer acs_sequencer_props u_props (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .sleep_req(sleep_req),
  .analog_out(analog_out));

// >>> tb/acs_core_model.sv
// analog multiplexer and converter core model facing the sequencer
`timescale 1ns/100ps
module acs_core_model (
  // clock
  input  wire logic                    clk,
  // input level before the channel and reference offset
  input  wire logic [9:0]              level_base,
  // sequencer side
  input  wire acs_pkg::acs_analog_type analog_out,
  output logic                         comparator_high
);
  logic [9:0] level;
  logic       idle_pat;
  // each channel and reference gives its own level, so a wrong pick shows
  assign level = level_base ^ {analog_out.channel_select, analog_out.reference_select, 7'h00};
  initial idle_pat = 1'b0;
  always @(posedge clk) idle_pat <= !idle_pat;
  // outside a held conversion the output toggles, never a settled answer
  assign comparator_high = (analog_out.core_enable && analog_out.hold) ?
                           (level >= analog_out.trial_code) : idle_pat;
endmodule

// >>> tb/tb_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tb_adc_conversion_sequencer;
  logic                    clk;
  logic                    rst_n;
  logic [4:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic                    irq;
  logic                    sleep_req;
  logic                    rc_clk_pin;
  logic                    comparator_high;
  logic [9:0]              level_base;
  acs_pkg::acs_analog_type analog_out;
  logic [7:0]              q;
  logic [9:0]              r_last;
  logic                    mask_on;
  logic                    hold_q;
  int                      n_fail;
  int                      samples_checked;
  int                      cyc;
  int                      t_rise;
  int                      hold_len;

  acs_sequencer u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .sleep_req(sleep_req), .rc_clk_pin(rc_clk_pin),
    .comparator_high(comparator_high), .analog_out(analog_out));
  acs_core_model u_core (.clk(clk), .level_base(level_base), .analog_out(analog_out),
    .comparator_high(comparator_high));

  always #20 clk = !clk;
  // rc oscillator runs free, unrelated in phase to clk
  always #2010 rc_clk_pin <= !rc_clk_pin;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hold_q <= analog_out.hold;
    if (hold_q === 1'b0 && analog_out.hold === 1'b1) t_rise <= cyc;
    if (hold_q === 1'b1 && analog_out.hold === 1'b0) hold_len <= cyc - t_rise;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
    end
  endtask

  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic conv(input logic [2:0] sel, input logic [1:0] ch, input logic rf,
                      input logic fm, input logic [9:0] lv, input logic exp_h);
    logic [9:0] r;
    logic [7:0] c;
    int         d;
    int         t;
    r = lv ^ {ch, rf, 7'h00};
    c = {fm, rf, 2'b00, ch, 2'b01};
    d = (sel[1:0] == 2'b11) ? 100 : 2 << (2 * sel[1:0] + sel[2]);
    t = 0;
    level_base <= lv;
    wr(5'h04, {1'b0, sel, 4'hF}); // pin direction is input on the board
    wr(5'h00, c); // power on apart from the start
    wr(5'h00, c | 8'h02);
    repeat (2) @(posedge clk);
    check({7'h00, analog_out.hold}, {7'h00, exp_h});
    do begin
      rd(5'h00);
      t++;
    end while (q[1] !== 1'b0 && t < 600);
    repeat (2) @(posedge clk);
    check(q, c);
    check({7'h00, hold_len >= 10 * d && hold_len <= 11 * d + d / 8 + 1}, 8'h01);
    // fast codes are only timed: the model core has no settling limit
    if (sel == 3'h6 || sel[1:0] == 2'b11) begin
      rd(5'h08);
      check(q, fm ? {6'h00, r[9:8]} : r[9:2]);
      rd(5'h0C);
      check(q, fm ? r[7:0] : {r[1:0], 6'h00});
      r_last = r;
    end
    check({7'h00, irq}, {7'h00, mask_on});
    rd(5'h10);
    check(q, 8'h40);
    rd(5'h10);
    check(q, 8'h00);
    check({7'h00, irq}, 8'h00);
  endtask

  task automatic t_regs();
    rd(5'h00);
    check(q, acs_pkg::CONTROL_RST);
    rd(5'h04);
    check(q, acs_pkg::ANALOG_RST);
    rd(5'h10);
    check(q, acs_pkg::FLAGS_RST);
    rd(5'h14);
    check(q, acs_pkg::MASK_RST);
    wr(5'h14, 8'hBF);
    rd(5'h14);
    check(q, 8'h00);
    wr(5'h04, 8'hF5);
    rd(5'h04);
    check(q, 8'h75);
    check({4'h0, analog_out.digital_input_disable}, 8'h05);
    wr(5'h18, 8'hFF);
    rd(5'h18);
    check(q, 8'h00);
    rd(5'h00);
    check(q, 8'h00);
  endtask

  task automatic t_codes();
    for (int s = 0; s < 8; s++) begin
      conv(3'(s), 2'(s), s[2], s[0], 10'h2A5, s % 4 != 3);
    end
    wr(5'h14, 8'h40);
    mask_on = 1'b1;
    conv(3'h6, 2'h0, 1'b0, 1'b1, 10'h3FF, 1'b1);
    conv(3'h6, 2'h1, 1'b0, 1'b0, 10'h000, 1'b1);
  endtask

  // abort mid conversion, restart inside the two period wait
  task automatic t_abort();
    level_base <= 10'h2AA;
    wr(5'h00, 8'hC5);
    wr(5'h00, 8'hC7);
    repeat (100) @(posedge clk);
    wr(5'h00, 8'hC5);
    rd(5'h08);
    check(q, {6'h00, r_last[9:8]});
    rd(5'h0C);
    check(q, r_last[7:0]);
    rd(5'h10);
    check(q, 8'h00);
    conv(3'h6, 2'h1, 1'b1, 1'b1, 10'h2AA, 1'b0);
  endtask

  task automatic t_sleep();
    wr(5'h00, 8'h01);
    wr(5'h00, 8'h03);
    repeat (100) @(posedge clk);
    sleep_req <= 1'b1;
    repeat (8) @(posedge clk);
    check({7'h00, analog_out.core_enable}, 8'h00);
    rd(5'h00);
    check(q, 8'h01);
    sleep_req <= 1'b0;
    rd(5'h10);
    check(q, 8'h00);
  endtask

  task automatic t_reset();
    wr(5'h00, 8'h01);
    wr(5'h00, 8'h03);
    repeat (100) @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(5'h00);
    check(q, 8'h00);
    rd(5'h08);
    check(q, r_last[9:2]);
    rd(5'h0C);
    check(q, {r_last[1:0], 6'h00});
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sleep_req = 1'b0;
    rc_clk_pin = 1'b0;
    level_base = 10'h000;
    mask_on = 1'b0;
    r_last = 10'h000;
    hold_q = 1'b0;
    {n_fail, samples_checked, cyc, t_rise, hold_len} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_codes();
    t_abort();
    t_sleep();
    t_reset();
    wrap_up();
  end
endmodule
